// File: jtsc_defs.svh
// Summary of operation
// - Test reset forces controller to reset state
// - Test reset makes identification the current instruction
// - Test reset puts boundary cells in system mode
// - Test reset loads chain select with three
// - Instruction register four bits, LSB first
// - Capture-IR loads constant 0001
// - Decode the ten public instruction codes
// - Sample on rising, drive output on falling
// - Extest: cells in test mode only with chain 0 selected, capture system values
// - Extest shift drives cells onto system immediately
// - Select-chain: capture 1000, shift chain number
// - Update-DR makes chosen chain stay connected
// - Chain select register four bits, LSB first
// - Leave-debug acts as bypass, exits on idle
// - Clamp drives cells from loaded chain values
// - Bypass captures zero, one clock delay path
// - Highz floats bus outputs, raises float indicator
// - Periphery chain order, debug request out first
// - Data chain 33 cells, breakpoint out first
// - Unassigned codes decode as bypass
// - Update-IR makes shifted value the current instruction
// - Identification captured, shifted LSB first, unchanged
// - Clamp-and-float disables the bus and data tristate outputs, not TDO
`ifndef JTSC_DEFS_SVH
`define JTSC_DEFS_SVH
`define JTSC_IR_EXTEST 4'h0
`define JTSC_IR_SCANN 4'h2
`define JTSC_IR_SAMPLE 4'h3
`define JTSC_IR_RESTART 4'h4
`define JTSC_IR_CLAMP 4'h5
`define JTSC_IR_HIGHZ 4'h7
`define JTSC_IR_CLAMP_FLOAT_INSTR 4'h9
`define JTSC_IR_INTEST 4'hc
`define JTSC_IR_IDCODE 4'he
`define JTSC_IR_BYPASS 4'hf
`define JTSC_IR_CAPTURE 4'h1
`define JTSC_SCAN_CAPTURE 4'h8
`define JTSC_CHAIN_RESET 4'h3
`define JTSC_C0_LEN 71
`define JTSC_C1_LEN 33
`define JTSC_CTRL_OFS 12'h000
`define JTSC_STAT_OFS 12'h004
`define JTSC_CTRL_TBE 0
`define JTSC_CTRL_DBG 1
`define JTSC_TMS_RESET_CNT 3'h5
`endif

// File: jtsc_host.sv
module jtsc_host (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_low,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_low = 1'b1;
  end

  // Reset pulse before the port is used
  task automatic pulse_reset();
    trst_low <= 1'b0;
    repeat (6) @(posedge clk);
    trst_low <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // One test clock: drive on the fall, read output late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    q = tdo;
  endtask

  task automatic idle();
    logic q;
    step(1'b0, 1'b0, q);
  endtask

  // From idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [71:0] din,
                      output logic [71:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tdi <= ~tdi;
  endtask

  task automatic to_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    idle();
  endtask
endmodule

// File: jtsc_pkg.sv
package jtsc_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jtsc_state_t;
  typedef enum logic [1:0] {DR_BYP, DR_ID, DR_SCANN, DR_CHAIN} jtsc_dr_t;
endpackage

// File: jtsc_top.sv
// The APB slave port and the register offsets were left to the implementer.
`include "jtsc_defs.svh"
module jtsc_top import jtsc_pkg::*; #(
  parameter logic [31:0] ID_VALUE = 32'h00000001  // Arbitrary identification value
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TAP_RESET_LOW,
  output logic TDO,
  output logic TDO_OE,
  output logic EXT_SCAN_IN,
  input wire logic EXT_SCAN_OUT,
  output logic [3:0] CHAIN_SEL,
  output logic [3:0] IR_CUR,
  input wire logic [31:0] CORE_DATA_OUT,
  input wire logic CORE_DATA_OE,
  input wire logic [31:0] CORE_ADDR,
  input wire logic [5:0] CORE_CTRL,
  output logic [31:0] CORE_DATA_IN,
  output logic CORE_BREAKPOINT_IN,
  output logic CORE_DEBUG_REQUEST_INTERNAL,
  input wire logic [31:0] PIN_DATA_IN,
  input wire logic BREAKPOINT_IN,
  input wire logic DEBUG_REQUEST_INTERNAL,
  output logic [31:0] PIN_DATA_OUT,
  output logic PIN_DATA_OE,
  output logic [31:0] PIN_ADDR,
  output logic [5:0] PIN_CTRL,
  output logic PIN_BUS_OE,
  output logic FLOAT_OUT,
  output logic DEBUG_EXIT,
  output logic DEBUG_STATE
);

  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction

  function automatic jtsc_dr_t dr_kind(input logic [3:0] ir);
    jtsc_dr_t k;
    k = DR_BYP;
    if (ir == `JTSC_IR_EXTEST || ir == `JTSC_IR_INTEST || ir == `JTSC_IR_SAMPLE) begin
      k = DR_CHAIN;
    end else if (ir == `JTSC_IR_SCANN) begin
      k = DR_SCANN;
    end else if (ir == `JTSC_IR_IDCODE) begin
      k = DR_ID;
    end
    return k;
  endfunction

  // Pin synchronisers
  logic [38:0] in_s1_r;
  logic [38:0] in_s2_r;
  logic tck_d_r;
  always_ff @(posedge SYS_CLK) begin
    in_s1_r <= {TCK, TMS, TDI, TAP_RESET_LOW, EXT_SCAN_OUT, BREAKPOINT_IN,
                DEBUG_REQUEST_INTERNAL, PIN_DATA_IN};
    in_s2_r <= in_s1_r;
    tck_d_r <= in_s2_r[38];
  end

  wire tck_s = in_s2_r[38];
  wire tms_s = in_s2_r[37];
  wire tdi_s = in_s2_r[36];
  wire trst_n_s = in_s2_r[35];
  wire sdo_s = in_s2_r[34];
  wire brk_s = in_s2_r[33];
  wire dbgrq_s = in_s2_r[32];
  wire [31:0] pin_d_s = in_s2_r[31:0];
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;
  wire tap_rst = RESET | ~trst_n_s;

  // Controller state
  jtsc_state_t state_r;
  jtsc_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TLR: state_nxt = tms_s ? TLR : RTI;
      RTI: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_DR: state_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = tms_s ? UPD_DR : PA_DR;
      PA_DR: state_nxt = tms_s ? EX2_DR : PA_DR;
      EX2_DR: state_nxt = tms_s ? UPD_DR : SH_DR;
      UPD_DR: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_IR: state_nxt = tms_s ? TLR : CAP_IR;
      CAP_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = tms_s ? UPD_IR : PA_IR;
      PA_IR: state_nxt = tms_s ? EX2_IR : PA_IR;
      EX2_IR: state_nxt = tms_s ? UPD_IR : SH_IR;
      UPD_IR: state_nxt = tms_s ? SEL_DR : RTI;
      default: state_nxt = TLR;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      state_r <= TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // Instruction path
  logic [3:0] ir_sr_r;
  logic [3:0] ir_r;
  logic [3:0] ir_sr_nxt;
  assign ir_sr_nxt = (state_r == CAP_IR) ? `JTSC_IR_CAPTURE :
                     (state_r == SH_IR) ? {tdi_s, ir_sr_r[3:1]} : ir_sr_r;
  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      ir_sr_r <= `JTSC_IR_CAPTURE;
      ir_r <= `JTSC_IR_IDCODE;
    end else if (tck_rise) begin
      ir_sr_r <= ir_sr_nxt;
      if (state_r == TLR) begin
        ir_r <= `JTSC_IR_IDCODE;
      end else if (state_r == UPD_IR) begin
        ir_r <= ir_sr_r;
      end
    end
  end

  // Data register decode
  logic [3:0] chain_r;
  wire jtsc_dr_t kind = dr_kind(ir_r);
  wire cap_dr = tck_rise & (state_r == CAP_DR);
  wire sh_dr = tck_rise & (state_r == SH_DR);
  wire on_chain = kind == DR_CHAIN;
  wire sel_c0 = on_chain & (chain_r == 4'h0);
  wire sel_c1 = on_chain & (chain_r == 4'h1);
  wire ext_num = ~(chain_r == 4'h0 || chain_r == 4'h1 || chain_r == 4'h2 ||
                   chain_r == 4'h4 || chain_r == 4'h8);
  wire sel_ext = on_chain & ext_num;

  // Bypass, identification and chain select registers
  logic byp_r;
  logic [31:0] id_r;
  logic [3:0] scan_sr_r;
  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      byp_r <= 1'b0;
    end else if (cap_dr) begin
      byp_r <= 1'b0;
    end else if (sh_dr) begin
      byp_r <= tdi_s;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      id_r <= 32'h0;
    end else if (cap_dr && kind == DR_ID) begin
      id_r <= ID_VALUE;
    end else if (sh_dr && kind == DR_ID) begin
      id_r <= {tdi_s, id_r[31:1]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      scan_sr_r <= `JTSC_SCAN_CAPTURE;
    end else if (cap_dr && kind == DR_SCANN) begin
      scan_sr_r <= `JTSC_SCAN_CAPTURE;
    end else if (sh_dr && kind == DR_SCANN) begin
      scan_sr_r <= {tdi_s, scan_sr_r[3:1]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      chain_r <= `JTSC_CHAIN_RESET;
    end else if (tck_rise && state_r == UPD_DR && kind == DR_SCANN) begin
      chain_r <= scan_sr_r;
    end
  end

  // Periphery chain and data chain, bit 0 leaves first
  logic [`JTSC_C0_LEN-1:0] sr0_r;
  logic [`JTSC_C1_LEN-1:0] sr1_r;
  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      sr0_r <= '0;
    end else if (cap_dr && sel_c0) begin
      sr0_r <= {rev32(pin_d_s), CORE_CTRL, CORE_ADDR, dbgrq_s};
    end else if (sh_dr && sel_c0) begin
      sr0_r <= {tdi_s, sr0_r[`JTSC_C0_LEN-1:1]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      sr1_r <= '0;
    end else if (cap_dr && sel_c1) begin
      sr1_r <= {rev32(pin_d_s), brk_s};
    end else if (sh_dr && sel_c1) begin
      sr1_r <= {tdi_s, sr1_r[`JTSC_C1_LEN-1:1]};
    end
  end

  // Serial output, launched on the falling test clock
  wire chain_bit = sel_c0 ? sr0_r[0] : sel_c1 ? sr1_r[0] : sel_ext ? sdo_s : byp_r;
  wire dr_bit = (kind == DR_ID) ? id_r[0] : (kind == DR_SCANN) ? scan_sr_r[0] :
                (kind == DR_CHAIN) ? chain_bit : byp_r;
  wire tdo_bit = (state_r == SH_IR) ? ir_sr_r[0] : dr_bit;
  wire shifting = (state_r == SH_IR) || (state_r == SH_DR);
  logic tdo_r;
  logic tdo_oe_r;
  logic ext_in_r;
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_bit;
      tdo_oe_r <= shifting;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ext_in_r <= 1'b0;
    end else if (tck_rise) begin
      ext_in_r <= tdi_s;
    end
  end

  // Boundary cell modes
  logic tbe_r;
  wire test_mode = (ir_r == `JTSC_IR_EXTEST || ir_r == `JTSC_IR_INTEST) &&
                   chain_r == 4'h0;
  wire clamp_mode = ir_r == `JTSC_IR_CLAMP || ir_r == `JTSC_IR_CLAMP_FLOAT_INSTR;
  wire drive_scan = test_mode | clamp_mode;
  wire highz_instr = ir_r == `JTSC_IR_HIGHZ;
  wire clamp_float_instr = ir_r == `JTSC_IR_CLAMP_FLOAT_INSTR;
  wire float_all = highz_instr | clamp_float_instr | ~tbe_r;
  wire [31:0] scan_data = rev32(sr0_r[70:39]);
  wire [31:0] pin_d_nxt = drive_scan ? scan_data : CORE_DATA_OUT;
  wire [31:0] addr_nxt = drive_scan ? sr0_r[32:1] : CORE_ADDR;
  wire [5:0] ctrl_nxt = drive_scan ? sr0_r[38:33] : CORE_CTRL;
  wire d_oe_nxt = ~float_all & (drive_scan ? sr0_r[33] : CORE_DATA_OE);
  wire [31:0] core_d_nxt = drive_scan ? scan_data : pin_d_s;
  wire core_dbg_nxt = drive_scan ? sr0_r[0] : dbgrq_s;

  logic [31:0] pin_d_r;
  logic [31:0] pin_a_r;
  logic [5:0] pin_c_r;
  logic pin_d_oe_r;
  logic bus_oe_r;
  logic float_r;
  logic [31:0] core_d_r;
  logic core_dbg_r;
  logic core_brk_r;
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pin_d_r <= 32'h0;
      pin_a_r <= 32'h0;
      pin_c_r <= 6'h0;
      pin_d_oe_r <= 1'b0;
      bus_oe_r <= 1'b0;
      float_r <= 1'b0;
    end else begin
      pin_d_r <= pin_d_nxt;
      pin_a_r <= addr_nxt;
      pin_c_r <= ctrl_nxt;
      pin_d_oe_r <= d_oe_nxt;
      bus_oe_r <= ~float_all;
      float_r <= highz_instr;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      core_d_r <= 32'h0;
      core_dbg_r <= 1'b0;
      core_brk_r <= 1'b0;
    end else begin
      core_d_r <= core_d_nxt;
      core_dbg_r <= core_dbg_nxt;
      core_brk_r <= brk_s;
    end
  end

  // Debug state exit on entry to run-test-idle
  logic dbg_r;
  logic dbg_exit_r;
  wire enter_rti = tck_rise & ~tap_rst & state_nxt == RTI & state_r != RTI;
  // Update-IR and the step into idle share one test clock rise
  wire [3:0] ir_entering = (state_r == UPD_IR) ? ir_sr_r : ir_r;
  wire restart_now = enter_rti & (ir_entering == `JTSC_IR_RESTART);

  // Register slave
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  wire apb_acc = PSEL & PENABLE;
  wire apb_wait = apb_acc & ~pready_r;
  wire apb_done = apb_acc & pready_r;
  wire hit_ctrl = PADDR == `JTSC_CTRL_OFS;
  wire hit_stat = PADDR == `JTSC_STAT_OFS;
  wire ctrl_wr = apb_done & PWRITE & hit_ctrl;
  wire dbg_set = ctrl_wr & PWDATA[`JTSC_CTRL_DBG];
  wire [31:0] ctrl_val = {30'h0, dbg_r, tbe_r};
  wire [31:0] stat_val = {19'h0, dbg_r, chain_r, ir_r, state_r};
  wire [31:0] rd_val = hit_ctrl ? ctrl_val : hit_stat ? stat_val : 32'h0;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apb_wait;
      pslverr_r <= apb_wait & ~(hit_ctrl | hit_stat);
      prdata_r <= apb_wait ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tbe_r <= 1'b1;
      dbg_r <= 1'b0;
      dbg_exit_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        tbe_r <= PWDATA[`JTSC_CTRL_TBE];
      end
      dbg_r <= dbg_set | (dbg_r & ~restart_now);
      dbg_exit_r <= restart_now & dbg_r;
    end
  end

  // Output map
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign TDO = tdo_r;
  assign TDO_OE = tdo_oe_r;
  assign EXT_SCAN_IN = ext_in_r;
  assign CHAIN_SEL = chain_r;
  assign IR_CUR = ir_r;
  assign CORE_DATA_IN = core_d_r;
  assign CORE_BREAKPOINT_IN = core_brk_r;
  assign CORE_DEBUG_REQUEST_INTERNAL = core_dbg_r;
  assign PIN_DATA_OUT = pin_d_r;
  assign PIN_DATA_OE = pin_d_oe_r;
  assign PIN_ADDR = pin_a_r;
  assign PIN_CTRL = pin_c_r;
  assign PIN_BUS_OE = bus_oe_r;
  assign FLOAT_OUT = float_r;
  assign DEBUG_EXIT = dbg_exit_r;
  assign DEBUG_STATE = dbg_r;

  // Checks
  logic [2:0] tms_cnt_r;
  always_ff @(posedge SYS_CLK) begin
    if (tap_rst) begin
      tms_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      tms_cnt_r <= !tms_s ? 3'h0 :
                   (tms_cnt_r == `JTSC_TMS_RESET_CNT) ? tms_cnt_r : tms_cnt_r + 3'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_trst_held;
    !trst_n_s [*2];
  endsequence

  sequence s_byp_capture;
    cap_dr && kind == DR_BYP && trst_n_s;
  endsequence

  a_trst_state: assert property (!trst_n_s |=> state_r == TLR)
    else $error("test reset did not force reset state");
  a_trst_instr: assert property (!trst_n_s |=> ir_r == `JTSC_IR_IDCODE)
    else $error("test reset did not select identification");
  a_trst_chain: assert property (!trst_n_s |=> chain_r == 4'h3)
    else $error("test reset did not select chain three");
  a_trst_sysmode: assert property (s_trst_held |=> PIN_ADDR == $past(CORE_ADDR))
    else $error("boundary cells not in system mode");
  a_cap_ir_value: assert property (tck_rise && state_r == CAP_IR && trst_n_s
    |=> ir_sr_r == 4'h1)
    else $error("capture-IR value wrong");
  a_update_ir_load: assert property (tck_rise && state_r == UPD_IR && trst_n_s
    |=> ir_r == $past(ir_sr_r))
    else $error("update-IR did not load instruction");
  a_five_tms_reset: assert property (tms_cnt_r == `JTSC_TMS_RESET_CNT |-> state_r == TLR)
    else $error("five high mode samples did not reset");
  a_bypass_zero: assert property (s_byp_capture |=> !byp_r)
    else $error("bypass did not capture zero");
  a_chain_update: assert property (tck_rise && state_r == UPD_DR && kind == DR_SCANN &&
    trst_n_s |=> chain_r == $past(scan_sr_r) ##1 chain_r == $past(chain_r))
    else $error("chain select not updated and held");
  a_tdo_on_fall: assert property ($changed(TDO) |-> $past(tck_fall))
    else $error("serial output changed off a falling edge");
  a_highz_float: assert property (highz_instr ##1 highz_instr |-> !PIN_BUS_OE && FLOAT_OUT)
    else $error("highz did not float the bus");
  a_restart_exit: assert property (restart_now && dbg_r |=> DEBUG_EXIT && !DEBUG_STATE)
    else $error("leave-debug did not exit debug state");

endmodule

// File: tb.sv
module tb import jtsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h1234_5679;  // Arbitrary identification value
  localparam logic [71:0] D = 72'h96_3c5a_e187_0f2d_b4c1;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, core_oe = 1'b1;
  logic ext_out, tdo_oe, core_brk, core_dbgi, pin_doe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, core_do = 32'h0f0f_1234, pin_di = 32'h0;
  logic [31:0] core_addr = 32'ha5c3_0e71, prdata, pin_addr;
  logic brk = 1'b1, dbgrq = 1'b1, exit_seen = 1'b0;
  logic pready, pslverr, tck, tms, tdi, trst_low, tdo, bus_oe, float_o, dbg_exit, dbg_st;
  logic [5:0] core_ctrl = 6'h2d, pin_ctrl;
  logic [3:0] chain_sel, ir_cur;
  int err_total = 0, comparisons = 0;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (dbg_exit) exit_seen <= 1'b1;

  jtsc_top #(.ID_VALUE(ID)) jtsc_top_i (
    .SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TAP_RESET_LOW(trst_low), .TDO(tdo), .TDO_OE(tdo_oe),
    .EXT_SCAN_IN(ext_out), .EXT_SCAN_OUT(ext_out), .CHAIN_SEL(chain_sel), .IR_CUR(ir_cur),
    .CORE_DATA_OUT(core_do), .CORE_DATA_OE(core_oe), .CORE_ADDR(core_addr),
    .CORE_CTRL(core_ctrl), .CORE_DATA_IN(), .CORE_BREAKPOINT_IN(core_brk),
    .CORE_DEBUG_REQUEST_INTERNAL(core_dbgi), .PIN_DATA_IN(pin_di), .BREAKPOINT_IN(brk),
    .DEBUG_REQUEST_INTERNAL(dbgrq), .PIN_DATA_OUT(), .PIN_DATA_OE(pin_doe),
    .PIN_ADDR(pin_addr), .PIN_CTRL(pin_ctrl), .PIN_BUS_OE(bus_oe), .FLOAT_OUT(float_o),
    .DEBUG_EXIT(dbg_exit), .DEBUG_STATE(dbg_st)
  );

  jtsc_host jtsc_host_i (
    .clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_low(trst_low), .tdo(tdo)
  );

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic load_ir(input logic [3:0] code);
    logic [71:0] o;
    jtsc_host_i.scan(1'b1, 4, {68'h0, code}, o);
    chk(o[3:0], 4'h1);
    chk(ir_cur, code);
  endtask

  task automatic sc_reset();
    logic [71:0] o;
    jtsc_host_i.pulse_reset();
    jtsc_host_i.idle();
    jtsc_host_i.scan(1'b0, 32, 72'h0, o);
    chk(o[31:0], ID);
    chk({tdo_oe, core_brk}, 2'b01);
  endtask

  task automatic sc_bypass();
    logic [71:0] o;
    logic [3:0] codes [9] = '{4'hf, 4'h4, 4'h7, 4'h9, 4'h1, 4'h6, 4'h8, 4'ha, 4'hd};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      jtsc_host_i.scan(1'b0, 8, 72'h5b, o);
      chk(o[7:0], 8'hb6);
      chk(float_o, codes[k] == 4'h7);
      chk(bus_oe, codes[k] != 4'h7 && codes[k] != 4'h9);
    end
  endtask

  task automatic sc_debug();
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h000, 32'h3, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk({dbg_st, r[1:0]}, 3'h7);
    load_ir(4'h4);
    repeat (2) @(posedge sys_clk);
    chk({exit_seen, dbg_st}, 2'b10);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({e, r}, 33'h1_0000_0000);
    apb(1'b1, 12'h000, 32'h0, r, e);
    repeat (3) @(posedge sys_clk);
    chk({bus_oe, pin_doe}, 2'b00);
    apb(1'b1, 12'h000, 32'h1, r, e);
  endtask

  task automatic sc_chains();
    logic [71:0] o;
    load_ir(4'h2);
    jtsc_host_i.scan(1'b0, 5, 72'h3, o);
    chk(o[4:0], 5'h18);
    load_ir(4'hc);
    chk(chain_sel, 4'h1);
    jtsc_host_i.scan(1'b0, 34, 72'h1, o);
    chk({o[33], o[0]}, 2'b11);
    load_ir(4'h2);
    jtsc_host_i.scan(1'b0, 4, 72'h0, o);
    load_ir(4'h0);
    jtsc_host_i.scan(1'b0, 72, D, o);
    chk(o[38:0], {core_ctrl, core_addr, dbgrq});
    chk(o[71], D[0]);
    chk({pin_ctrl, pin_addr}, D[39:2]);
    chk(core_dbgi, D[1]);
    load_ir(4'h5);
    core_addr <= 32'h1357_9bdf;
    jtsc_host_i.scan(1'b0, 8, 72'h5b, o);
    chk(o[7:0], 8'hb6);
    chk(pin_addr, D[33:2]);
    load_ir(4'h0);
  endtask

  task automatic sc_trst();
    logic [71:0] o;
    logic [31:0] r;
    logic e;
    jtsc_host_i.pulse_reset();
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r[3:0], TLR);
    chk(r[11:4], 8'h3e);
    chk(pin_addr, core_addr);
    jtsc_host_i.idle();
    load_ir(4'h0);
    jtsc_host_i.scan(1'b0, 8, 72'h5b, o);
    chk(o[7:0], 8'hb6);
    load_ir(4'hf);
    jtsc_host_i.to_reset();
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r[7:0], 8'he1);
  endtask

  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    sc_reset();
    sc_bypass();
    sc_debug();
    sc_chains();
    sc_trst();
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
endmodule
